//--- hdl/irq_response_pkg.sv
// Constants for the processor interrupt response unit
// Function
// - Non-maskable input acts on falling edge, unmaskable
// - Non-maskable entry: DMA stop, push, save, disable
// - Non-maskable entry jumps to 0066H
// - Nonmaskable return restores saved enable flag
// - Latched edge taken at sample, ack after cycle
// - Input 0 sampled low at sample point
// - Input 0 masked by global or own enable
// - Input 0 below non-maskable, above others
// - Mode set by instruction; reset mode 0
// - Mode 0 captures instruction at T3, no push
// - Undefined mode 0 instruction raises trap
// - Mode 1 pushes, clears both flags, jumps 0038H
// - Mode 2 table on vector page boundary
// - Mode 2 byte at T3, push, table jump
// - Vector fetch drives both strobes, two waits
// - Vector page register resets to zero
// - Other sources build vector from low register
// - Fixed source codes and priority order
// - Inputs 1, 2 masked globally and individually
// - Reset clears global flag, input 1/2 enables
// - Peripheral requests vectored, gated by enables
// - Disable clears, enable sets global flag
// - Inputs 1, 2 sampled low at sample point
package irq_response_pkg;
   localparam logic [15:0] NMI_RESTART_ADDR   = 16'h0066;
   localparam logic [15:0] MODE1_RESTART_ADDR = 16'h0038;
   localparam logic [1:0]  IRQ_MODE0          = 2'h0;
   localparam logic [1:0]  IRQ_MODE1          = 2'h1;
   localparam logic [1:0]  IRQ_MODE2          = 2'h2;
   localparam logic [1:0]  RST_IRQ_MODE       = IRQ_MODE0;
   localparam logic [2:0]  RST_EXT_ENABLE     = 3'h1;
   localparam logic [7:0]  RST_VECTOR_PAGE    = 8'h00;
   localparam logic [2:0]  RST_VECTOR_LOW     = 3'h0;
   localparam logic [1:0]  AUTO_WAIT_STATES   = 2'h2;
   localparam int          VEC_TABLE_ENTRIES  = 128;
   localparam int          NUM_PERIPH         = 7;
   localparam int          NUM_VEC_SRC        = 9;
   localparam int          EXT0_EN_BIT        = 0;
   localparam int          EXT1_EN_BIT        = 1;
   localparam int          EXT2_EN_BIT        = 2;
   localparam int          PIN_NMI            = 0;
   localparam int          PIN_REQ0           = 1;
   localparam int          PIN_REQ1           = 2;
   localparam int          PIN_REQ2           = 3;

   typedef enum logic [2:0] {
      KIND_NMI,
      KIND_M0,
      KIND_M1,
      KIND_M2,
      KIND_VEC
   } src_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PEND,
      ST_FETCH,
      ST_M0_EXEC
   } resp_state_t;
endpackage

//--- hdl/irq_response_unit.sv
// Interrupt acceptance and vectoring unit
`timescale 1ns/1ps
`default_nettype none
module irq_response_unit (
   // Clock and reset
   input  wire logic        CLK_SYS_IN,
   input  wire logic        RST_B_IN,
   // Interrupt pins, active low, asynchronous
   input  wire logic        NONMASKABLE_REQ_N_IN,
   input  wire logic        MASKABLE_REQUEST0_N_IN,
   input  wire logic        MASKABLE_REQUEST1_N_IN,
   input  wire logic        MASKABLE_REQUEST2_N_IN,
   // On-chip peripheral requests and their enables
   input  wire logic [6:0]  PERIPH_REQ_IN,
   input  wire logic [6:0]  PERIPH_EN_IN,
   // Core timing strobes
   input  wire logic        SAMPLE_POINT_IN,
   input  wire logic        MCYCLE_END_IN,
   input  wire logic        T3_RISE_IN,
   input  wire logic [7:0]  DATA_BUS_IN,
   input  wire logic        UNDEF_OPCODE_IN,
   // Instruction strobes from the decoder
   input  wire logic        IRQ_ENABLE_INSTR_IN,
   input  wire logic        IRQ_DISABLE_INSTR_IN,
   input  wire logic        RETURN_FROM_NONMASKABLE_IN,
   input  wire logic        SET_IRQ_MODE_INSTR_IN,
   input  wire logic [1:0]  IRQ_MODE_SEL_IN,
   // Register writes
   input  wire logic        TRAP_CONTROL_WR_IN,
   input  wire logic [2:0]  EXT_IRQ_ENABLE_IN,
   input  wire logic        VECTOR_PAGE_WR_IN,
   input  wire logic [7:0]  VECTOR_PAGE_IN,
   input  wire logic        VECTOR_LOW_WR_IN,
   input  wire logic [2:0]  VECTOR_LOW_IN,
   // Entry request to the core
   output logic             ENTRY_PULSE_OUT,
   output logic             PUSH_PC_OUT,
   output logic             USE_TABLE_OUT,
   output logic [15:0]      TARGET_ADDR_OUT,
   output logic             DMA_ENABLE_CLEAR_OUT,
   output logic             INSTR_VALID_OUT,
   output logic [7:0]       INSTR_OUT,
   output logic             TRAP_OUT,
   // Acknowledge bus strobes
   output logic             OPCODE_FETCH_STROBE_N_OUT,
   output logic             IO_REQUEST_STROBE_N_OUT,
   output logic             AUTO_WAIT_STATE_OUT,
   output logic             ACK_BUSY_OUT,
   // Status
   output logic             GLOBAL_IRQ_ENABLE_OUT,
   output logic             SAVED_IRQ_ENABLE_OUT,
   output logic [1:0]       IRQ_MODE_OUT,
   output logic [2:0]       EXT_IRQ_ENABLE_OUT,
   output logic [7:0]       VECTOR_PAGE_OUT,
   output logic [2:0]       VECTOR_LOW_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge detection

   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic        nmi_prev_r;
   logic        nmi_fall;

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sync1_r    <= 4'hf;
         sync2_r    <= 4'hf;
         nmi_prev_r <= 1'b1;
      end else begin
         sync1_r    <= {MASKABLE_REQUEST2_N_IN, MASKABLE_REQUEST1_N_IN,
                        MASKABLE_REQUEST0_N_IN, NONMASKABLE_REQ_N_IN};
         sync2_r    <= sync1_r;
         nmi_prev_r <= sync2_r[irq_response_pkg::PIN_NMI];
      end
   end

   assign nmi_fall = nmi_prev_r & ~sync2_r[irq_response_pkg::PIN_NMI];

   ////////////////////////////////////////////////////////////////////////////
   // Request gating and priority

   logic        global_irq_enable_r;
   logic        saved_irq_enable_r;
   logic [1:0]  mode_r;
   logic [2:0]  ite_r;
   logic [7:0]  vpage_r;
   logic [2:0]  vlow_r;
   logic        nmi_pend_r;
   logic        maskable_request0_n_req;
   logic [8:0]  vreq;
   logic        vhit;
   logic [3:0]  vsel;

   assign maskable_request0_n_req = ~sync2_r[irq_response_pkg::PIN_REQ0] & global_irq_enable_r
                     & ite_r[irq_response_pkg::EXT0_EN_BIT];
   assign vreq[0]  = ~sync2_r[irq_response_pkg::PIN_REQ1] & global_irq_enable_r
                     & ite_r[irq_response_pkg::EXT1_EN_BIT];
   assign vreq[1]  = ~sync2_r[irq_response_pkg::PIN_REQ2] & global_irq_enable_r
                     & ite_r[irq_response_pkg::EXT2_EN_BIT];

   genvar g;
   generate
      for (g = 0; g < irq_response_pkg::NUM_PERIPH; g++) begin : g_periph
         assign vreq[g+2] = PERIPH_REQ_IN[g] & PERIPH_EN_IN[g] & global_irq_enable_r;
      end
   endgenerate

   assign vhit = |vreq;

   // Lowest index wins
   always_comb begin
      vsel = 4'h0;
      for (int i = irq_response_pkg::NUM_VEC_SRC - 1; i >= 0; i--) begin
         if (vreq[i]) begin
            vsel = 4'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge sequencer

   irq_response_pkg::resp_state_t  state_r, state_nxt;
   irq_response_pkg::src_kind_t    kind_r, kind_nxt;
   logic [3:0]   vidx_r, vidx_nxt;
   logic [1:0]   wait_r, wait_nxt;
   logic [7:0]   instr_r, instr_nxt;
   logic         entry_r, entry_nxt;
   logic         push_r, push_nxt;
   logic         table_r, table_nxt;
   logic [15:0]  addr_r, addr_nxt;
   logic         dmaclr_r, dmaclr_nxt;
   logic         ivalid_r, ivalid_nxt;
   logic         trap_r, trap_nxt;
   logic         nmi_taken;
   logic         nmi_enter;
   logic         mask_enter;

   always_comb begin
      state_nxt  = state_r;
      kind_nxt   = kind_r;
      vidx_nxt   = vidx_r;
      wait_nxt   = wait_r;
      instr_nxt  = instr_r;
      entry_nxt  = 1'b0;
      push_nxt   = 1'b0;
      table_nxt  = table_r;
      addr_nxt   = addr_r;
      dmaclr_nxt = 1'b0;
      ivalid_nxt = 1'b0;
      trap_nxt   = 1'b0;
      nmi_taken  = 1'b0;
      nmi_enter  = 1'b0;
      mask_enter = 1'b0;
      unique case (state_r)
         irq_response_pkg::ST_IDLE: begin
            if (SAMPLE_POINT_IN) begin
               if (nmi_pend_r) begin
                  kind_nxt  = irq_response_pkg::KIND_NMI;
                  nmi_taken = 1'b1;
                  state_nxt = irq_response_pkg::ST_PEND;
               end else if (maskable_request0_n_req) begin
                  if (mode_r == irq_response_pkg::IRQ_MODE1) begin
                     kind_nxt = irq_response_pkg::KIND_M1;
                  end else if (mode_r == irq_response_pkg::IRQ_MODE2) begin
                     kind_nxt = irq_response_pkg::KIND_M2;
                  end else begin
                     kind_nxt = irq_response_pkg::KIND_M0;
                  end
                  state_nxt = irq_response_pkg::ST_PEND;
               end else if (vhit) begin
                  kind_nxt  = irq_response_pkg::KIND_VEC;
                  vidx_nxt  = vsel;
                  state_nxt = irq_response_pkg::ST_PEND;
               end
            end
         end
         irq_response_pkg::ST_PEND: begin
            if (MCYCLE_END_IN) begin
               unique case (kind_r)
                  irq_response_pkg::KIND_NMI: begin
                     entry_nxt  = 1'b1;
                     push_nxt   = 1'b1;
                     dmaclr_nxt = 1'b1;
                     nmi_enter  = 1'b1;
                     table_nxt  = 1'b0;
                     addr_nxt   = irq_response_pkg::NMI_RESTART_ADDR;
                     state_nxt  = irq_response_pkg::ST_IDLE;
                  end
                  irq_response_pkg::KIND_M1: begin
                     entry_nxt  = 1'b1;
                     push_nxt   = 1'b1;
                     mask_enter = 1'b1;
                     table_nxt  = 1'b0;
                     addr_nxt   = irq_response_pkg::MODE1_RESTART_ADDR;
                     state_nxt  = irq_response_pkg::ST_IDLE;
                  end
                  irq_response_pkg::KIND_VEC: begin
                     entry_nxt  = 1'b1;
                     push_nxt   = 1'b1;
                     mask_enter = 1'b1;
                     table_nxt  = 1'b1;
                     addr_nxt   = {vpage_r, vlow_r, vidx_r, 1'b0};
                     state_nxt  = irq_response_pkg::ST_IDLE;
                  end
                  default: begin
                     mask_enter = 1'b1;
                     wait_nxt   = (kind_r == irq_response_pkg::KIND_M2) ?
                                  irq_response_pkg::AUTO_WAIT_STATES : 2'h0;
                     state_nxt  = irq_response_pkg::ST_FETCH;
                  end
               endcase
            end
         end
         irq_response_pkg::ST_FETCH: begin
            if (T3_RISE_IN) begin
               if (wait_r != 2'h0) begin
                  wait_nxt = wait_r - 2'h1;
               end else if (kind_r == irq_response_pkg::KIND_M2) begin
                  entry_nxt = 1'b1;
                  push_nxt  = 1'b1;
                  table_nxt = 1'b1;
                  addr_nxt  = {vpage_r, DATA_BUS_IN};
                  state_nxt = irq_response_pkg::ST_IDLE;
               end else begin
                  instr_nxt  = DATA_BUS_IN;
                  ivalid_nxt = 1'b1;
                  state_nxt  = irq_response_pkg::ST_M0_EXEC;
               end
            end
         end
         irq_response_pkg::ST_M0_EXEC: begin
            trap_nxt  = UNDEF_OPCODE_IN;
            state_nxt = irq_response_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         state_r  <= irq_response_pkg::ST_IDLE;
         kind_r   <= irq_response_pkg::KIND_NMI;
         vidx_r   <= 4'h0;
         wait_r   <= 2'h0;
         instr_r  <= 8'h00;
         entry_r  <= 1'b0;
         push_r   <= 1'b0;
         table_r  <= 1'b0;
         addr_r   <= 16'h0000;
         dmaclr_r <= 1'b0;
         ivalid_r <= 1'b0;
         trap_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         kind_r   <= kind_nxt;
         vidx_r   <= vidx_nxt;
         wait_r   <= wait_nxt;
         instr_r  <= instr_nxt;
         entry_r  <= entry_nxt;
         push_r   <= push_nxt;
         table_r  <= table_nxt;
         addr_r   <= addr_nxt;
         dmaclr_r <= dmaclr_nxt;
         ivalid_r <= ivalid_nxt;
         trap_r   <= trap_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable flags, mode and vector registers

   logic        global_irq_enable_nxt;
   logic        saved_irq_enable_nxt;
   logic [1:0]  mode_nxt;
   logic [2:0]  ite_nxt;
   logic [7:0]  vpage_nxt;
   logic [2:0]  vlow_nxt;
   logic        nmi_pend_nxt;

   always_comb begin
      global_irq_enable_nxt  = global_irq_enable_r;
      saved_irq_enable_nxt  = saved_irq_enable_r;
      mode_nxt  = mode_r;
      ite_nxt   = ite_r;
      vpage_nxt = vpage_r;
      vlow_nxt  = vlow_r;
      nmi_pend_nxt = nmi_fall | (nmi_pend_r & ~nmi_taken);
      if (nmi_enter) begin
         saved_irq_enable_nxt = global_irq_enable_r;
         global_irq_enable_nxt = 1'b0;
      end else if (mask_enter) begin
         global_irq_enable_nxt = 1'b0;
         saved_irq_enable_nxt = 1'b0;
      end else if (RETURN_FROM_NONMASKABLE_IN) begin
         global_irq_enable_nxt = saved_irq_enable_r;
      end else if (IRQ_ENABLE_INSTR_IN) begin
         global_irq_enable_nxt = 1'b1;
         saved_irq_enable_nxt = 1'b1;
      end else if (IRQ_DISABLE_INSTR_IN) begin
         global_irq_enable_nxt = 1'b0;
         saved_irq_enable_nxt = 1'b0;
      end
      if (SET_IRQ_MODE_INSTR_IN && IRQ_MODE_SEL_IN != 2'h3) begin
         mode_nxt = IRQ_MODE_SEL_IN;
      end
      if (TRAP_CONTROL_WR_IN) begin
         ite_nxt = EXT_IRQ_ENABLE_IN;
      end
      if (VECTOR_PAGE_WR_IN) begin
         vpage_nxt = VECTOR_PAGE_IN;
      end
      if (VECTOR_LOW_WR_IN) begin
         vlow_nxt = VECTOR_LOW_IN;
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         global_irq_enable_r     <= 1'b0;
         saved_irq_enable_r     <= 1'b0;
         mode_r     <= irq_response_pkg::RST_IRQ_MODE;
         ite_r      <= irq_response_pkg::RST_EXT_ENABLE;
         vpage_r    <= irq_response_pkg::RST_VECTOR_PAGE;
         vlow_r     <= irq_response_pkg::RST_VECTOR_LOW;
         nmi_pend_r <= 1'b0;
      end else begin
         global_irq_enable_r     <= global_irq_enable_nxt;
         saved_irq_enable_r     <= saved_irq_enable_nxt;
         mode_r     <= mode_nxt;
         ite_r      <= ite_nxt;
         vpage_r    <= vpage_nxt;
         vlow_r     <= vlow_nxt;
         nmi_pend_r <= nmi_pend_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign ENTRY_PULSE_OUT           = entry_r;
   assign PUSH_PC_OUT               = push_r;
   assign USE_TABLE_OUT             = table_r;
   assign TARGET_ADDR_OUT           = addr_r;
   assign DMA_ENABLE_CLEAR_OUT      = dmaclr_r;
   assign INSTR_VALID_OUT           = ivalid_r;
   assign INSTR_OUT                 = instr_r;
   assign TRAP_OUT                  = trap_r;
   assign OPCODE_FETCH_STROBE_N_OUT = (state_r != irq_response_pkg::ST_FETCH);
   assign IO_REQUEST_STROBE_N_OUT   = (state_r != irq_response_pkg::ST_FETCH);
   assign AUTO_WAIT_STATE_OUT       = (state_r == irq_response_pkg::ST_FETCH) && (wait_r != 2'h0);
   assign ACK_BUSY_OUT              = (state_r != irq_response_pkg::ST_IDLE);
   assign GLOBAL_IRQ_ENABLE_OUT     = global_irq_enable_r;
   assign SAVED_IRQ_ENABLE_OUT      = saved_irq_enable_r;
   assign IRQ_MODE_OUT              = mode_r;
   assign EXT_IRQ_ENABLE_OUT        = ite_r;
   assign VECTOR_PAGE_OUT           = vpage_r;
   assign VECTOR_LOW_OUT            = vlow_r;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);

   sequence s_fetch_capture;
      (state_r == irq_response_pkg::ST_FETCH) && T3_RISE_IN && (wait_r == 2'h0);
   endsequence

   a_nmi_edge_pending: assert property (nmi_fall |=> nmi_pend_r)
      else $error("falling edge not latched");
   a_nmi_entry_flags: assert property ((state_r == irq_response_pkg::ST_PEND) && MCYCLE_END_IN
      && (kind_r == irq_response_pkg::KIND_NMI) |=> dmaclr_r && push_r && !global_irq_enable_r
      && (saved_irq_enable_r == $past(global_irq_enable_r)))
      else $error("nonmaskable entry flags wrong");
   a_nmi_target_addr: assert property (entry_r && dmaclr_r |-> TARGET_ADDR_OUT == 16'h0066)
      else $error("nonmaskable target wrong");
   a_return_from_nonmaskable_restore: assert property (RETURN_FROM_NONMASKABLE_IN && !nmi_enter && !mask_enter
      |=> global_irq_enable_r == $past(saved_irq_enable_r))
      else $error("saved flag not restored");
   a_masked_req0_ignored: assert property ((state_r == irq_response_pkg::ST_IDLE) && SAMPLE_POINT_IN
      && !nmi_pend_r && !vhit && (!global_irq_enable_r || !ite_r[0]) |=> state_r == irq_response_pkg::ST_IDLE)
      else $error("masked request taken");
   a_nmi_over_req0: assert property ((state_r == irq_response_pkg::ST_IDLE) && SAMPLE_POINT_IN
      && nmi_pend_r |=> kind_r == irq_response_pkg::KIND_NMI)
      else $error("priority order broken");
   a_mode0_no_push: assert property (s_fetch_capture ##0 (kind_r == irq_response_pkg::KIND_M0)
      |=> ivalid_r && !push_r && (instr_r == $past(DATA_BUS_IN)) ##1 !ivalid_r)
      else $error("mode 0 capture wrong");
   a_mode0_trap: assert property (ivalid_r && UNDEF_OPCODE_IN |=> trap_r)
      else $error("trap not raised");
   a_mode1_entry: assert property (entry_r && !table_r && !dmaclr_r
      |-> TARGET_ADDR_OUT == 16'h0038 && push_r && !global_irq_enable_r && !saved_irq_enable_r)
      else $error("mode 1 entry wrong");
   a_mode2_pointer: assert property (s_fetch_capture ##0 (kind_r == irq_response_pkg::KIND_M2)
      |=> entry_r && push_r && table_r && TARGET_ADDR_OUT == {vpage_r, $past(DATA_BUS_IN)})
      else $error("mode 2 pointer wrong");
   a_vector_wait_states: assert property ((state_r == irq_response_pkg::ST_PEND) && MCYCLE_END_IN
      && (kind_r == irq_response_pkg::KIND_M2) |=> AUTO_WAIT_STATE_OUT && !OPCODE_FETCH_STROBE_N_OUT
      && !IO_REQUEST_STROBE_N_OUT && wait_r == 2'h2)
      else $error("vector fetch strobes wrong");
   a_vector_low_code: assert property (entry_r && table_r && !saved_irq_enable_r && $past(kind_r) ==
      irq_response_pkg::KIND_VEC |-> TARGET_ADDR_OUT[4:0] == {$past(vidx_r), 1'b0}
      && TARGET_ADDR_OUT[7:5] == vlow_r)
      else $error("vector code wrong");
endmodule
`default_nettype wire

//--- tb/irq_requester_model.sv
// Model of the external devices that request and answer acknowledges
`timescale 1ns/1ps
`default_nettype none
module irq_requester_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   // Bench commands
   input  wire logic [2:0] raise_in,
   input  wire logic [7:0] reply_in,
   // Acknowledge side
   input  wire logic       fetch_n_in,
   input  wire logic       ioreq_n_in,
   input  wire logic       ack_in,
   // Pins
   output logic [2:0]      req_n_out,
   output logic [7:0]      data_out
);
   logic       drv;
   logic [7:0] last_r;
   assign drv = !fetch_n_in && !ioreq_n_in;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_n_out <= 3'h7;
         last_r    <= 8'h00;
      end else begin
         req_n_out <= ack_in ? 3'h7 : (req_n_out & ~raise_in);
         last_r    <= drv ? reply_in : ~last_r;
      end
   end
   // Bus carries the reply while both strobes are low and for one cycle after they rise
   assign data_out = drv ? reply_in : last_r;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the interrupt response unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_b, nmi_n, sp, mce, t3, undef, ei, di, return_from_nonmaskable, setm, tcw, vpw, vlw;
   logic [1:0] msel, mode_o;
   logic [2:0] ext_en, vlow, raise, req_n, en_o, low_o;
   logic [6:0] preq, pen;
   logic [7:0] vpage, reply, data, instr, page_o;
   logic [15:0] target;
   logic entry, push, use_tbl, dma_clr, ivalid, trap, fetch_n, ioreq_n, awt, busy, gie, sie;
   int n_errors, check_count, cycles;
   ////////////////////////////////////////////////////////////////
   irq_response_unit uut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .NONMASKABLE_REQ_N_IN(nmi_n),
      .MASKABLE_REQUEST0_N_IN(req_n[0]), .MASKABLE_REQUEST1_N_IN(req_n[1]),
      .MASKABLE_REQUEST2_N_IN(req_n[2]), .PERIPH_REQ_IN(preq), .PERIPH_EN_IN(pen),
      .SAMPLE_POINT_IN(sp), .MCYCLE_END_IN(mce), .T3_RISE_IN(t3), .DATA_BUS_IN(data),
      .UNDEF_OPCODE_IN(undef), .IRQ_ENABLE_INSTR_IN(ei), .IRQ_DISABLE_INSTR_IN(di),
      .RETURN_FROM_NONMASKABLE_IN(return_from_nonmaskable), .SET_IRQ_MODE_INSTR_IN(setm), .IRQ_MODE_SEL_IN(msel),
      .TRAP_CONTROL_WR_IN(tcw), .EXT_IRQ_ENABLE_IN(ext_en), .VECTOR_PAGE_WR_IN(vpw),
      .VECTOR_PAGE_IN(vpage), .VECTOR_LOW_WR_IN(vlw), .VECTOR_LOW_IN(vlow),
      .ENTRY_PULSE_OUT(entry), .PUSH_PC_OUT(push), .USE_TABLE_OUT(use_tbl),
      .TARGET_ADDR_OUT(target), .DMA_ENABLE_CLEAR_OUT(dma_clr), .INSTR_VALID_OUT(ivalid),
      .INSTR_OUT(instr), .TRAP_OUT(trap), .OPCODE_FETCH_STROBE_N_OUT(fetch_n),
      .IO_REQUEST_STROBE_N_OUT(ioreq_n), .AUTO_WAIT_STATE_OUT(awt), .ACK_BUSY_OUT(busy),
      .GLOBAL_IRQ_ENABLE_OUT(gie), .SAVED_IRQ_ENABLE_OUT(sie), .IRQ_MODE_OUT(mode_o),
      .EXT_IRQ_ENABLE_OUT(en_o), .VECTOR_PAGE_OUT(page_o), .VECTOR_LOW_OUT(low_o));
   irq_requester_model peer (.clk_in(clk), .rst_b_in(rst_b), .raise_in(raise), .reply_in(reply),
      .fetch_n_in(fetch_n), .ioreq_n_in(ioreq_n), .ack_in(entry | ivalid), .req_n_out(req_n),
      .data_out(data));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   task automatic step(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Sample point, then end of machine cycle; returns in the entry cycle, or in the first fetch cycle in modes 0 and 2
   task automatic take();
      sp = 1;
      step();
      sp = 0;
      mce = 1;
      step();
      mce = 0;
   endtask
   task automatic set_mode(logic [1:0] m);
      setm = 1;
      msel = m;
      step();
      setm = 0;
   endtask
   task automatic enable();
      ei = 1;
      step();
      ei = 0;
   endtask
   task automatic request(logic [2:0] r);
      raise = r;
      step();
      raise = 0;
      step(3);
   endtask
   task automatic conclude();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {sp, mce, t3, undef, ei, di, return_from_nonmaskable, setm, tcw, vpw, vlw, rst_b} = '0;
      {msel, ext_en, vlow, raise, preq, pen, vpage, reply} = '0;
      nmi_n = 1;
      step(10);
      rst_b = 1;
      step();
      chk("reset flags", 16'h0008, {6'h0, gie, sie, mode_o, en_o, low_o});
      chk("reset page", 16'h0300, {6'h0, fetch_n, ioreq_n, page_o});
      {tcw, ext_en, vpw, vpage, vlw, vlow} = {1'b1, 3'h7, 1'b1, 8'h12, 1'b1, 3'h5};
      step();
      {tcw, vpw, vlw} = '0;
      request(3'h3);
      take();
      chk("masked", 16'h0, {entry, busy});
      enable();
      chk("global on", 16'h1, gie);
      set_mode(2'h3);
      chk("mode 3 ignored", 16'h0, mode_o);
      set_mode(2'h1);
      chk("mode set", 16'h1, mode_o);
      take();
      chk("mode1 entry", 16'h0038, target);
      chk("mode1 flags", 16'h11, {push, use_tbl, gie, sie, entry});
      enable();
      nmi_n = 0;
      step(3);
      take();
      nmi_n = 1;
      chk("nmi entry", 16'h0066, target);
      chk("nmi flags", 16'hd, {dma_clr, push, gie, sie});
      return_from_nonmaskable = 1;
      step();
      return_from_nonmaskable = 0;
      chk("nmi return", 16'h1, gie);
      di = 1;
      step();
      di = 0;
      chk("disable", 16'h0, {gie, sie});
      enable();
      preq = 7'h01;
      take();
      chk("periph gated", 16'h0, {entry, busy});
      pen = 7'h7f;
      for (int i = 0; i < 9; i++) begin
         enable();
         if (i < 2) request(3'h2 << i);
         else begin
            // Let the acknowledged pin clear through the synchroniser
            step(2);
            preq = 7'h01 << (i - 2);
         end
         take();
         preq = 0;
         chk("vector", {8'h12, 3'h5, 5'(2 * i)}, target);
         chk("vector kind", 16'h7, {entry, push, use_tbl});
      end
      enable();
      set_mode(2'h2);
      reply = 8'h5c;
      request(3'h1);
      take();
      chk("m2 strobes", 16'h1, {fetch_n, ioreq_n, awt});
      for (int k = 0; k < 3; k++) begin
         if (k > 0) step();
         t3 = 1;
         step();
         t3 = 0;
      end
      chk("m2 pointer", 16'h125c, target);
      chk("m2 kind", 16'h7, {entry, push, use_tbl});
      enable();
      set_mode(2'h0);
      reply = 8'hc7;
      undef = 1;
      request(3'h1);
      take();
      chk("m0 strobes", 16'h0, {fetch_n, ioreq_n});
      t3 = 1;
      step();
      t3 = 0;
      chk("m0 capture", 16'h01c7, {push, ivalid, instr});
      step();
      chk("m0 trap", 16'h1, trap);
      undef = 0;
      conclude();
   end
endmodule
`default_nettype wire
